// ==== flash_lock_params.svh ====
// Constants for the flash protection lock and status block
`ifndef FLASH_LOCK_PARAMS_SVH
`define FLASH_LOCK_PARAMS_SVH

// Opcodes served here
`define FL_OP_WR_STATUS 8'h01
`define FL_OP_RD_STATUS 8'h05

// Status byte field positions
`define FL_POS_LOCK 7
`define FL_POS_SEQ 6
`define FL_POS_SPARE 5
`define FL_POS_GUARD 4
`define FL_POS_SUM_HI 3
`define FL_POS_SUM_LO 2
`define FL_POS_LATCH 1
`define FL_POS_BUSY 0

// Protection summary codes
`define FL_SUM_NONE 2'h0
`define FL_SUM_SOME 2'h1
`define FL_SUM_ALL 2'h3

// Sector layout
`define FL_N_SECTORS 11
`define FL_SECT_IDX_W 4

// Reset values
`define FL_RST_LOCK 1'h0
`define FL_RST_LATCH 1'h0
`define FL_RST_SECT 1'h1
`define FL_RST_SO 1'h0
`define FL_RST_PINS 4'he
`define FL_RST_BYTE 8'h00

// Bit counting
`define FL_BIT_FIRST 3'h0
`define FL_BIT_LAST 3'h7
`define FL_BIT_STEP 3'h1

`endif

// ==== flash_lock_pkg.sv ====
// Types shared by the flash protection lock and status block
`include "flash_lock_params.svh"

package flash_lock_pkg;

    typedef struct packed {
        logic prot_table_lock;
        logic seq_prog_flag;
        logic spare_bit;
        logic guard_pin_state;
        logic [1:0] soft_prot_summary;
        logic write_latch;
        logic busy_flag;
    } status_flags_s;

    typedef struct packed {
        logic valid;
        logic set;
        logic [`FL_SECT_IDX_W-1:0] idx;
    } sector_cmd_s;

    typedef struct packed {
        logic guard_b;
        logic si;
        logic cs_b;
        logic sck;
    } serial_pins_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_OPCODE = 5'h02,
        ST_RD_STATUS = 5'h04,
        ST_WR_DATA = 5'h08,
        ST_IGNORE = 5'h10
    } serial_state_e;

endpackage : flash_lock_pkg

// ==== pin_sync.sv ====
// Two-stage synchroniser with edge detect for external pins
module pin_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out,
    output logic [WIDTH-1:0] fall_out
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;

    // Only the second stage and later are looked at
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta <= RST_VAL;
            stable <= RST_VAL;
            prev <= RST_VAL;
        end else if (clk_en_in) begin
            meta <= async_in;
            stable <= meta;
            prev <= stable;
        end
    end

    assign level_out = stable;
    assign rise_out = stable & ~prev;
    assign fall_out = ~stable & prev;

endmodule : pin_sync

// ==== flash_protect_lock_status.sv ====
// Protection lock, status register and status read/write over the serial link
//
// Notes on behaviour
// RULE1: Hardware lock is on only when guard pin asserted and lock bit is one.
// RULE2: Hardware lock ignores protect, unprotect and status write; bits frozen.
// RULE3: Guard pin never changes sector bits; protected means bit one.
// RULE4: With guard asserted, a set lock bit clears only by reset.
// RULE5: With guard released, lock may still be set, then sector commands ignored.
// RULE6: Software lock (guard released, lock one) lets a status write clear lock.
// RULE7: Lock zero: lock may be set and sector commands run normally.
// RULE8: Status read is accepted at any time, even while busy.
// RULE9: After opcode 05h the device shifts one status bit per clock.
// RULE10: Status shifted MSB first, wrapping from bit 0 back to bit 7.
// RULE11: Each repeated status byte is sampled fresh from live state.
// RULE12: Select release ends the read at once and floats the output.
// RULE13: Bit 7 is the lock bit, writable, zero after reset.
// RULE14: Bit 6 is the read-only sequential programming flag.
// RULE15: Bit 4 reads zero while guard pin asserted, one when released.
// RULE16: Bits 3:2 give protection summary, 00 none, 01 some, 11 all.
// RULE17: Bit 1 is a read-only copy of the write-enable latch.
// RULE18: Bit 0 reads one while an internal operation runs.
// RULE19: Only bit 7 is changed by a status write.
// RULE20: Status write is opcode 01h plus one byte; only its bit 7 counts.
// RULE21: Clearing lock with guard asserted is ignored, latch still cleared.
// RULE22: Summary derived from sector bits: all zero, all one, else some.
// RULE23: Host drives the guard pin low to assert it.
`include "flash_lock_params.svh"

module flash_protect_lock_status
    import flash_lock_pkg::*;
#(
    parameter int N_SECTORS = `FL_N_SECTORS
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    input wire logic sck_in,
    input wire logic cs_b_in,
    input wire logic si_in,
    input wire logic guard_b_in,
    input wire logic busy_in,
    input wire logic seq_prog_in,
    input wire logic latch_set_in,
    input wire logic latch_clr_in,
    input wire sector_cmd_s sector_cmd_in,
    output logic so_out,
    output logic so_oe_out,
    output status_flags_s status_out,
    output logic [N_SECTORS-1:0] sector_prot_out,
    output logic write_latch_out,
    output logic hw_lock_out
);

    // Summary of the sector protection bits
    function automatic logic [1:0] summarise(
        input logic [N_SECTORS-1:0] prot
    );
        logic [1:0] code;
        code = `FL_SUM_SOME;
        if (prot == '0) begin
            code = `FL_SUM_NONE;
        end else if (prot == '1) begin
            code = `FL_SUM_ALL;
        end
        return code;
    endfunction : summarise

    // Synchronised pins
    serial_pins_s pins_raw;
    serial_pins_s pins_lvl;
    serial_pins_s pins_rise;
    serial_pins_s pins_fall;

    assign pins_raw.guard_b = guard_b_in;
    assign pins_raw.si = si_in;
    assign pins_raw.cs_b = cs_b_in;
    assign pins_raw.sck = sck_in;

    // Pins come from the host's domain, so every one is resynchronised
    pin_sync #(
        .WIDTH($bits(serial_pins_s)),
        .RST_VAL(`FL_RST_PINS)
    ) u_pin_sync (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .clk_en_in(clk_en_in),
        .async_in(pins_raw),
        .level_out(pins_lvl),
        .rise_out(pins_rise),
        .fall_out(pins_fall)
    );

    // State
    serial_state_e state;
    serial_state_e next_state;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic wr_full;
    logic wr_lock_val;
    logic [7:0] rd_shadow;
    logic [2:0] rd_idx;
    logic lock;
    logic write_latch;
    logic [N_SECTORS-1:0] sector_prot;

    // Pin events
    wire sck_rise = pins_rise.sck;
    wire sck_fall = pins_fall.sck;
    wire cs_start = pins_fall.cs_b;
    wire cs_end = pins_rise.cs_b;
    wire si_bit = pins_lvl.si;
    wire guard_asserted = ~pins_lvl.guard_b;

    // State decode
    wire in_idle = (state == ST_IDLE);
    wire in_opcode = (state == ST_OPCODE);
    wire in_rd = (state == ST_RD_STATUS);
    wire in_wr = (state == ST_WR_DATA);

    // Shift path
    wire [7:0] shift_in = {shift[6:0], si_bit};
    wire last_bit = (bit_cnt == `FL_BIT_LAST);
    wire byte_done = sck_rise & last_bit;
    wire op_done = in_opcode & byte_done & ~cs_end;
    wire is_rd_op = (shift_in == `FL_OP_RD_STATUS);
    wire is_wr_op = (shift_in == `FL_OP_WR_STATUS);
    wire shift_en = sck_rise & (in_opcode | (in_wr & ~wr_full));
    wire [2:0] next_bit_cnt = cs_start ? `FL_BIT_FIRST
        : shift_en ? bit_cnt + `FL_BIT_STEP : bit_cnt;
    wire [7:0] next_shift = cs_start ? `FL_RST_BYTE
        : shift_en ? shift_in : shift;

    // Locking decode
    wire hw_lock = guard_asserted & lock; // RULE1

    // Status write: only data bit 7 is used
    wire wr_catch = in_wr & ~wr_full & byte_done;
    wire next_wr_full = cs_start ? 1'h0 : (wr_full | wr_catch);
    wire next_wr_lock_val = wr_catch ? shift_in[`FL_POS_LOCK] : wr_lock_val; // RULE20
    // Opcode taken in full, so the latch clears whether it runs or aborts
    wire wsr_end = in_wr & cs_end;
    wire clear_blocked = guard_asserted & ~wr_lock_val; // RULE4 RULE21
    wire wsr_allowed = ~hw_lock & ~clear_blocked; // RULE2 RULE6 RULE7
    wire wsr_exec = wsr_end & wr_full & write_latch & wsr_allowed;
    wire next_lock = wsr_exec ? wr_lock_val : lock; // RULE13 RULE19

    // Sector commands from the program/erase engines
    // Lock one covers both hardware and software locking
    wire sect_ok = write_latch & ~lock; // RULE2 RULE5 RULE7
    wire sect_exec = sector_cmd_in.valid & sect_ok;
    logic [N_SECTORS-1:0] next_sector_prot;

    genvar gi;
    generate
        for (gi = 0; gi < N_SECTORS; gi++) begin : g_sect
            wire hit = sect_exec
                & (sector_cmd_in.idx == `FL_SECT_IDX_W'(gi));
            // Guard pin is not in this path at all
            assign next_sector_prot[gi] = hit ? sector_cmd_in.set
                : sector_prot[gi]; // RULE3
        end
    endgenerate

    // Write-enable latch; a set in the same cycle as a clear wins
    wire latch_clear = latch_clr_in | wsr_end | sector_cmd_in.valid; // RULE21
    wire next_write_latch = latch_set_in | (write_latch & ~latch_clear);

    // Live status byte, rebuilt every cycle
    status_flags_s live_status;
    assign live_status.prot_table_lock = lock; // RULE13
    assign live_status.seq_prog_flag = seq_prog_in; // RULE14
    assign live_status.spare_bit = 1'h0;
    assign live_status.guard_pin_state = pins_lvl.guard_b; // RULE15
    assign live_status.soft_prot_summary = summarise(sector_prot); // RULE16 RULE22
    assign live_status.write_latch = write_latch; // RULE17
    assign live_status.busy_flag = busy_in; // RULE18

    // Status read path
    wire rd_enter = op_done & is_rd_op; // RULE8 RULE9
    wire rd_shift = in_rd & sck_fall & ~cs_end;
    wire rd_wrap = (rd_idx == `FL_BIT_FIRST);
    // A fresh copy is taken as bit 0 leaves, so busy changes show next pass
    wire rd_reload = rd_enter | (rd_shift & rd_wrap); // RULE11
    wire [7:0] next_rd_shadow = rd_reload ? live_status : rd_shadow;
    wire [2:0] next_rd_idx = rd_reload ? `FL_BIT_LAST
        : rd_shift ? rd_idx - `FL_BIT_STEP : rd_idx; // RULE10
    wire next_so = rd_shift ? rd_shadow[rd_idx] : so_out; // RULE9 RULE10
    wire next_so_oe = (cs_end | pins_lvl.cs_b) ? 1'h0
        : (rd_shift | so_oe_out); // RULE12

    // Command sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cs_start) begin
                    next_state = ST_OPCODE;
                end
            end
            ST_OPCODE: begin
                if (cs_end) begin
                    next_state = ST_IDLE;
                end else if (byte_done) begin
                    if (is_rd_op) begin
                        next_state = ST_RD_STATUS;
                    end else if (is_wr_op) begin
                        next_state = ST_WR_DATA;
                    end else begin
                        next_state = ST_IGNORE;
                    end
                end
            end
            ST_RD_STATUS: begin
                if (cs_end) begin
                    next_state = ST_IDLE; // RULE12
                end
            end
            ST_WR_DATA: begin
                if (cs_end) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IGNORE: begin
                if (cs_end) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= ST_IDLE;
        end else if (clk_en_in) begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bit_cnt <= `FL_BIT_FIRST;
            shift <= `FL_RST_BYTE;
        end else if (clk_en_in) begin
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_full <= 1'h0;
        end else if (clk_en_in) begin
            wr_full <= next_wr_full;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_lock_val <= `FL_RST_LOCK;
        end else if (clk_en_in) begin
            wr_lock_val <= next_wr_lock_val;
        end
    end

    // Only reset brings the lock back to zero once guard holds it
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lock <= `FL_RST_LOCK;
        end else if (clk_en_in) begin
            lock <= next_lock; // RULE4
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            write_latch <= `FL_RST_LATCH;
        end else if (clk_en_in) begin
            write_latch <= next_write_latch;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sector_prot <= {N_SECTORS{`FL_RST_SECT}};
        end else if (clk_en_in) begin
            sector_prot <= next_sector_prot;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_shadow <= `FL_RST_BYTE;
        end else if (clk_en_in) begin
            rd_shadow <= next_rd_shadow;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_idx <= `FL_BIT_LAST;
        end else if (clk_en_in) begin
            rd_idx <= next_rd_idx;
        end
    end

    // Output does not idle at a stale bit: enable drops with select
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            so_out <= `FL_RST_SO;
            so_oe_out <= 1'h0;
        end else if (clk_en_in) begin
            so_out <= next_so;
            so_oe_out <= next_so_oe;
        end
    end

    // Registered copies for the engines and for observation
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            status_out <= '0;
            sector_prot_out <= {N_SECTORS{`FL_RST_SECT}};
            write_latch_out <= `FL_RST_LATCH;
            hw_lock_out <= 1'h0;
        end else if (clk_en_in) begin
            status_out <= live_status;
            sector_prot_out <= sector_prot;
            write_latch_out <= write_latch;
            hw_lock_out <= hw_lock;
        end
    end

endmodule : flash_protect_lock_status

// ==== flash_protect_lock_status_assertions.sv ====
// Port-level assertions for the flash lock and status block
module flash_lock_checker
    import flash_lock_pkg::*;
#(
    parameter int N_SECTORS = 11
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    input wire logic cs_b_in,
    input wire logic busy_in,
    input wire logic seq_prog_in,
    input wire logic latch_set_in,
    input wire logic so_oe_out,
    input wire status_flags_s status_out,
    input wire logic [N_SECTORS-1:0] sector_prot_out,
    input wire logic write_latch_out,
    input wire logic hw_lock_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    hw_lock_a:
        assert property (hw_lock_out
            == (status_out.prot_table_lock && !status_out.guard_pin_state))
        else $error("hardware lock flag disagrees with status");
    lock_hold_a:
        assert property (hw_lock_out |=> status_out.prot_table_lock)
        else $error("lock bit dropped under hardware lock");
    prot_sum_a:
        assert property ($past(rst_b_in) |-> status_out.soft_prot_summary ==
            (&sector_prot_out ? 2'h3 : (|sector_prot_out ? 2'h1 : 2'h0)))
        else $error("protection summary wrong");
    latch_copy_a:
        assert property (status_out.write_latch == write_latch_out)
        else $error("latch status bit differs from latch");
    latch_set_a:
        assert property (latch_set_in && clk_en_in ##1 clk_en_in |=> write_latch_out)
        else $error("latch not set after write enable");
    so_off_a:
        assert property (cs_b_in [*5] |-> !so_oe_out)
        else $error("output still driven after select release");
    busy_bit_a:
        assert property ($past(rst_b_in, 2) && $stable(busy_in) [*3]
            |-> status_out.busy_flag == busy_in)
        else $error("busy bit does not follow engine");
    seq_bit_a:
        assert property ($past(rst_b_in, 2) && $stable(seq_prog_in) [*3]
            |-> status_out.seq_prog_flag == seq_prog_in)
        else $error("mode bit does not follow engine");
    sect_gate_a:
        assert property ($changed(sector_prot_out)
            |-> $past(write_latch_out) && !$past(status_out.prot_table_lock))
        else $error("sector bits changed while refused");
    cover property (hw_lock_out);
    cover property (so_oe_out && status_out.busy_flag);
    cover property ($changed(sector_prot_out));
endmodule : flash_lock_checker

// ==== spi_host_model.sv ====
// Behavioural serial host driving the link in mode 0
module spi_host_model (
    output logic sck_out,
    output logic cs_b_out,
    output logic si_out,
    input wire logic so_in,
    input wire logic so_oe_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sck_out = 1'h0;
        cs_b_out = 1'h1;
        si_out = 1'h0;
    end
    // Samples late in the high phase, since the synced output lags the fall
    task automatic frame(input logic [7:0] op, input logic [7:0] d, input int n,
                         input int hp, output logic [63:0] q);
        logic [15:0] w;
        w = {op, d};
        q = '0;
        cs_b_out = 1'h0;
        #(hp);
        for (int i = 0; i < n; i++) begin
            si_out = (i < 16) ? w[15-i] : ~si_out;
            #(hp) sck_out = 1'h1;
            #(hp);
            if (i >= 8)
                q = {q[62:0], so_oe_in ? so_in : 1'bx};
            sck_out = 1'h0;
        end
        #(hp);
        cs_b_out = 1'h1;
        si_out = ~si_out;
    endtask : frame
endmodule : spi_host_model

// ==== flash_protect_lock_status_test.sv ====
// Self-checking bench for the flash lock and status block
module flash_protect_lock_status_test
    import flash_lock_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_in, rst_b_in, clk_en_in, guard_b_in, busy_in, seq_prog_in;
    logic latch_set_in, latch_clr_in;
    logic so_out, so_oe_out, write_latch_out, hw_lock_out, sck, cs_b, si;
    sector_cmd_s sector_cmd_in;
    status_flags_s status_out;
    logic [10:0] sector_prot_out;
    logic [63:0] q;
    int fails, checks;
    flash_protect_lock_status dut (
        .sys_clk_in, .rst_b_in, .clk_en_in, .sck_in(sck), .cs_b_in(cs_b), .si_in(si),
        .guard_b_in, .busy_in, .seq_prog_in, .latch_set_in, .latch_clr_in, .sector_cmd_in,
        .so_out, .so_oe_out, .status_out, .sector_prot_out, .write_latch_out, .hw_lock_out);
    spi_host_model host (.sck_out(sck), .cs_b_out(cs_b), .si_out(si), .so_in(so_out),
        .so_oe_in(so_oe_out));
    initial begin
        sys_clk_in = 1'h0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic clk(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : clk
    task automatic latch_pulse;
        latch_set_in = 1'h1;
        clk(1);
        latch_set_in = 1'h0;
    endtask : latch_pulse
    task automatic sec(input int i, input logic s, input logic w);
        if (w) latch_pulse();
        sector_cmd_in = '{1'h1, s, 4'(i)};
        clk(1);
        sector_cmd_in.valid = 1'h0;
        clk(3);
    endtask : sec
    task automatic wst(input logic [7:0] d, input logic w);
        if (w) latch_pulse();
        host.frame(8'h01, d, 16, 160, q);
        clk(6);
    endtask : wst
    task automatic rd(input int n, input logic [63:0] e);
        host.frame(8'h05, 8'h00, n, 160, q);
        chk(q, e);
        clk(6);
    endtask : rd
    task automatic tdone(input int n);
        $display("test %0d done", n);
    endtask : tdone
    task automatic report_and_stop;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        #2ms;
        fails++;
        report_and_stop();
    end
    initial begin
        rst_b_in = 1'h0;
        guard_b_in = 1'h1;
        {clk_en_in, busy_in, seq_prog_in, latch_set_in, latch_clr_in} = 5'h10;
        sector_cmd_in = '0;
        clk(6);
        rst_b_in = 1'h1;
        clk(4);
        rd(24, 64'h1c1c);
        chk(64'(sector_prot_out), 64'h7ff);
        tdone(1);
        busy_in = 1'h1;
        seq_prog_in = 1'h1;
        clk(3);
        // Busy drops mid byte so only the following bytes see it
        fork
            host.frame(8'h05, 8'h00, 32, 160, q);
            begin
                clk(100);
                busy_in = 1'h0;
            end
        join
        chk(q, 64'h5d5c5c);
        seq_prog_in = 1'h0;
        clk(4);
        host.frame(8'h05, 8'h00, 12, 240, q);
        clk(5);
        chk(64'(so_oe_out), 64'h0);
        chk(q, 64'h1);
        tdone(2);
        sec(3, 1'h0, 1'h1);
        chk(64'(sector_prot_out), 64'h7f7);
        chk(64'(status_out), 64'h14);
        latch_pulse();
        latch_clr_in = 1'h1;
        clk(1);
        latch_clr_in = 1'h0;
        sec(4, 1'h0, 1'h0);
        chk(64'(sector_prot_out), 64'h7f7);
        for (int i = 0; i < 11; i++) sec(i, 1'h0, 1'h1);
        chk(64'(status_out), 64'h10);
        sec(0, 1'h1, 1'h1);
        chk(64'(sector_prot_out), 64'h1);
        tdone(3);
        wst(8'h80, 1'h1);
        chk(64'(status_out), 64'h94);
        chk(64'(hw_lock_out), 64'h0);
        sec(0, 1'h0, 1'h1);
        chk(64'(sector_prot_out), 64'h1);
        wst(8'h00, 1'h0);
        chk(64'(status_out), 64'h94);
        wst(8'h7f, 1'h1);
        chk(64'(status_out), 64'h14);
        tdone(4);
        guard_b_in = 1'h0;
        clk(6);
        wst(8'hff, 1'h1);
        chk(64'(status_out), 64'h84);
        chk(64'(hw_lock_out), 64'h1);
        rd(16, 64'h84);
        wst(8'h00, 1'h1);
        chk(64'(status_out), 64'h84);
        sec(0, 1'h0, 1'h1);
        chk(64'(sector_prot_out), 64'h1);
        guard_b_in = 1'h1;
        clk(6);
        chk(64'(status_out), 64'h94);
        rst_b_in = 1'h0;
        clk(2);
        rst_b_in = 1'h1;
        clk(4);
        chk(64'(status_out), 64'h1c);
        tdone(5);
        // Unknown opcode must leave the latch alone
        latch_pulse();
        host.frame(8'h07, 8'h80, 16, 160, q);
        clk(6);
        chk(64'(write_latch_out), 64'h1);
        chk(64'(status_out), 64'h1e);
        latch_clr_in = 1'h1;
        clk(1);
        latch_clr_in = 1'h0;
        clk(2);
        clk_en_in = 1'h0;
        latch_pulse();
        clk(3);
        chk(64'(write_latch_out), 64'h0);
        clk_en_in = 1'h1;
        clk(3);
        chk(64'(write_latch_out), 64'h0);
        tdone(6);
        report_and_stop();
    end
endmodule : flash_protect_lock_status_test
bind flash_protect_lock_status flash_lock_checker #(.N_SECTORS(N_SECTORS)) chk_i (
    .sys_clk_in, .rst_b_in, .clk_en_in, .cs_b_in, .busy_in, .seq_prog_in, .latch_set_in,
    .so_oe_out,
    .status_out, .sector_prot_out, .write_latch_out, .hw_lock_out);
